// ===== logic/ssc_pkg.sv
// constants and types for spindle sync control
package ssc_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int CLK_NS = 20;
	localparam int LOCK_TIME_S = 6;
	localparam int LOCK_CYC = LOCK_TIME_S * CLK_HZ;
	localparam int LOCK_TOL_US = 20;
	localparam int LOCK_TOL_CYC = (LOCK_TOL_US * 1000) / CLK_NS;
	localparam int REV_PERIOD_US = 8333;
	localparam int REV_CYC = (REV_PERIOD_US * 1000) / CLK_NS;
	localparam int FWD_DELAY_NS = 350;
	localparam int FWD_DELAY_CYC = FWD_DELAY_NS / CLK_NS;
	localparam int PULSE_US = 2;
	localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_NS;
	localparam int OFS_DENOM = 256;
	localparam int OFS_W = 8;
	localparam int CNT_W = 32;
	localparam logic [7:0] OFS_NONE = 8'h00;
	// mode field encodings
	typedef enum logic [1:0] {
		SSC_MODE_OFF = 2'h0,
		SSC_MODE_FOLLOW = 2'h1,
		SSC_MODE_LEAD = 2'h2,
		SSC_MODE_LEADCTL = 2'h3
	} ssc_mode_t;
	typedef enum logic [1:0] {
		SSC_ST_IDLE = 2'h0,
		SSC_ST_ACQUIRE = 2'h1,
		SSC_ST_LOCKED = 2'h3,
		SSC_ST_LEAD = 2'h2
	} ssc_state_t;
endpackage

// ===== logic/ssc_spindle_sync_control.sv
// spindle synchronisation: mode control, marker emit, follow, forward
// Operation
// RL1 - three modes selected by mode field: disabled, follower, leader
// RL2 - disabled mode emits no markers and ignores received markers
// RL3 - follower locks spindle phase to markers from link or wire
// RL4 - leader follows nothing and emits one marker per revolution
// RL5 - marker goes out as link sync character or wire pulse
// RL6 - leader-control variant is refused and treated as disabled
// RL7 - follower takes up to six seconds to achieve lock
// RL8 - media read and write blocked while lock is being acquired
// RL9 - once locked, phase held within twenty microseconds of markers
// RL10 - leader delivers markers every 8.333 ms within 2.08 us
// RL11 - eight-bit offset sets lag of value/256 revolution, zero disables
// RL12 - offset applied as a lag, never as a lead
// RL13 - offset used only in follower mode
// RL14 - sync character forwarded to other port after 350 ns
// RL15 - forward delay may grow 50 ns behind RR or ACK second character
// RL16 - forward delay may grow 50 ns more behind SAT character
// RL17 - wire pulse is two microseconds active low, open drain
// RL18 - external wire pulses last at least one microsecond
// RL19 - exactly one leader on a shared wire
// RL20 - sync wire double-synchronised, each falling edge one marker
`timescale 1ns/10ps
module ssc_spindle_sync_control import ssc_pkg::*; #(
	parameter int LOCK_CYCLES = LOCK_CYC,
	parameter int REV_CYCLES = REV_CYC,
	parameter int FWD_CYCLES = FWD_DELAY_CYC,
	parameter int PULSE_CYCLES = PULSE_CYC,
	parameter int TOL_CYCLES = LOCK_TOL_CYC
) (
	input wire logic refClk,
	input wire logic rst,
	input wire logic [1:0] spindleLockModeField,
	input wire logic [OFS_W-1:0] rotOffset,
	input wire logic useWire,
	input wire logic revIndex,
	input wire logic linkSyncInA,
	input wire logic linkSyncInB,
	input wire logic portBusyA,
	input wire logic portBusyB,
	input wire logic syncWireIn,
	output logic syncWireOut,
	output logic syncWireOe,
	output logic linkSyncOutA,
	output logic linkSyncOutB,
	output logic phaseAdvance,
	output logic phaseRetard,
	output logic locked,
	output logic mediaBlocked,
	output logic modeRefused
);
	ssc_state_t state_ff, nxt_state;
	ssc_mode_t mode;
	logic wireS1_ff, wireS2_ff, wireS3_ff;
	logic wireMarker;
	logic rxMarker;
	logic [CNT_W-1:0] lockCnt_ff;
	logic [CNT_W-1:0] phaseCnt_ff;
	logic [CNT_W-1:0] pulseCnt_ff;
	logic [CNT_W-1:0] fwdCntA_ff, fwdCntB_ff;
	logic fwdPendA_ff, fwdPendB_ff;
	logic [CNT_W-1:0] target;
	logic [CNT_W-1:0] errCnt;

	assign mode = ssc_mode_t'(spindleLockModeField);

	// RL20 two-stage synchroniser
	always_ff @(posedge refClk) begin
		if (rst) begin
			wireS1_ff <= 1'b1;
			wireS2_ff <= 1'b1;
			wireS3_ff <= 1'b1;
		end else begin
			wireS1_ff <= syncWireIn;
			wireS2_ff <= wireS1_ff;
			wireS3_ff <= wireS2_ff;
		end
	end
	// RL20 falling edge marker
	assign wireMarker = wireS3_ff & ~wireS2_ff;
	// RL3 marker from either route
	assign rxMarker = useWire ? wireMarker : (linkSyncInA | linkSyncInB);

	// RL1 mode selection
	always_comb begin
		nxt_state = state_ff;
		case (mode)
			SSC_MODE_FOLLOW: begin
				if (state_ff != SSC_ST_ACQUIRE && state_ff != SSC_ST_LOCKED) begin
					nxt_state = SSC_ST_ACQUIRE;
				end else if (state_ff == SSC_ST_ACQUIRE && lockCnt_ff >= CNT_W'(LOCK_CYCLES - 1)) begin
					// RL7 lock within six seconds
					nxt_state = SSC_ST_LOCKED;
				end
			end
			SSC_MODE_LEAD: nxt_state = SSC_ST_LEAD;
			// RL6 leader-control refused
			default: nxt_state = SSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge refClk) begin
		if (rst) begin
			state_ff <= SSC_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge refClk) begin
		if (rst || state_ff != SSC_ST_ACQUIRE) begin
			lockCnt_ff <= '0;
		end else begin
			lockCnt_ff <= lockCnt_ff + 1'b1;
		end
	end

	// revolution phase counter, reset on own index mark
	always_ff @(posedge refClk) begin
		if (rst || revIndex || phaseCnt_ff >= CNT_W'(REV_CYCLES - 1)) begin
			phaseCnt_ff <= '0;
		end else begin
			phaseCnt_ff <= phaseCnt_ff + 1'b1;
		end
	end

	// RL11 lag of offset/256 revolution
	// RL13 offset only in follower mode
	always_comb begin
		target = '0;
		if (rotOffset != OFS_NONE) begin
			// RL12 lag: own index falls this far after marker
			target = CNT_W'(REV_CYCLES - (REV_CYCLES / OFS_DENOM) * int'(rotOffset));
		end
	end
	// phase error at marker, taken modulo one revolution so an early own phase does not wrap
	assign errCnt = (phaseCnt_ff >= target) ? (phaseCnt_ff - target) :
		(phaseCnt_ff + CNT_W'(REV_CYCLES) - target);

	// RL3 phase correction on each received marker
	// RL9 deadband of twenty microseconds once locked
	always_ff @(posedge refClk) begin
		if (rst) begin
			phaseAdvance <= 1'b0;
			phaseRetard <= 1'b0;
		end else begin
			phaseAdvance <= 1'b0;
			phaseRetard <= 1'b0;
			// RL2 idle and leader ignore markers
			if (rxMarker && (state_ff == SSC_ST_ACQUIRE || state_ff == SSC_ST_LOCKED)) begin
				if (errCnt > CNT_W'(TOL_CYCLES) && errCnt < CNT_W'(REV_CYCLES / 2)) begin
					phaseRetard <= 1'b1;
				end else if (errCnt >= CNT_W'(REV_CYCLES / 2) && errCnt < CNT_W'(REV_CYCLES - TOL_CYCLES)) begin
					phaseAdvance <= 1'b1;
				end
			end
		end
	end

	// RL8 media blocked while acquiring
	always_ff @(posedge refClk) begin
		if (rst) begin
			locked <= 1'b0;
			mediaBlocked <= 1'b0;
			modeRefused <= 1'b0;
		end else begin
			locked <= (nxt_state == SSC_ST_LOCKED);
			mediaBlocked <= (nxt_state == SSC_ST_ACQUIRE);
			modeRefused <= (mode == SSC_MODE_LEADCTL);
		end
	end

	// RL17 two microsecond active-low pulse
	// RL4 one wire pulse per revolution as leader
	always_ff @(posedge refClk) begin
		if (rst) begin
			pulseCnt_ff <= '0;
			syncWireOut <= 1'b1;
			syncWireOe <= 1'b0;
		end else if (state_ff == SSC_ST_LEAD && useWire && revIndex) begin
			pulseCnt_ff <= CNT_W'(PULSE_CYCLES);
			syncWireOut <= 1'b0;
			syncWireOe <= 1'b1;
		end else if (pulseCnt_ff > CNT_W'(1)) begin
			pulseCnt_ff <= pulseCnt_ff - 1'b1;
		end else begin
			pulseCnt_ff <= '0;
			syncWireOut <= 1'b1;
			syncWireOe <= 1'b0;
		end
	end

	// RL14 forward after 350 ns
	// RL15 RR/ACK busy stretches the wait
	// RL16 SAT busy stretches it further
	always_ff @(posedge refClk) begin
		if (rst) begin
			fwdPendA_ff <= 1'b0;
			fwdCntA_ff <= '0;
			linkSyncOutB <= 1'b0;
		end else begin
			linkSyncOutB <= 1'b0;
			if (linkSyncInA) begin
				fwdPendA_ff <= 1'b1;
				fwdCntA_ff <= CNT_W'(FWD_CYCLES - 1);
			end else if (fwdPendA_ff && fwdCntA_ff != '0) begin
				fwdCntA_ff <= fwdCntA_ff - 1'b1;
			end else if (fwdPendA_ff && !portBusyB) begin
				fwdPendA_ff <= 1'b0;
				linkSyncOutB <= 1'b1;
			end
		end
	end

	// RL5 leader marker as link character
	always_ff @(posedge refClk) begin
		if (rst) begin
			fwdPendB_ff <= 1'b0;
			fwdCntB_ff <= '0;
			linkSyncOutA <= 1'b0;
		end else begin
			linkSyncOutA <= 1'b0;
			if (linkSyncInB) begin
				fwdPendB_ff <= 1'b1;
				fwdCntB_ff <= CNT_W'(FWD_CYCLES - 1);
			end else if (state_ff == SSC_ST_LEAD && !useWire && revIndex) begin
				fwdPendB_ff <= 1'b1;
				fwdCntB_ff <= '0;
			end else if (fwdPendB_ff && fwdCntB_ff != '0) begin
				fwdCntB_ff <= fwdCntB_ff - 1'b1;
			end else if (fwdPendB_ff && !portBusyA) begin
				fwdPendB_ff <= 1'b0;
				linkSyncOutA <= 1'b1;
			end
		end
	end

	// forwarding tail beyond the eight-cycle quiet check
	localparam int FWD_TAIL = FWD_CYCLES - 8;
	sequence sqFwdQuiet;
		!linkSyncInA && !portBusyB;
	endsequence
	// RL14 forward timing: B out FWD_CYCLES+1 edges after A in
	AST_FWD_DELAY: assert property (@(posedge refClk) disable iff (rst) // RL14
		linkSyncInA ##1 sqFwdQuiet[*8] ##FWD_TAIL sqFwdQuiet |-> ##1 linkSyncOutB)
		else $error("forward delay wrong");
	// RL16 busy port holds the character
	AST_FWD_STALL: assert property (@(posedge refClk) disable iff (rst) // RL16
		(fwdPendA_ff && fwdCntA_ff == '0 && portBusyB && !linkSyncInA) |=> !linkSyncOutB && fwdPendA_ff)
		else $error("forward sent into busy port");

	// RL17 pulse width
	sequence sqPulseStart;
		$fell(syncWireOut);
	endsequence
	AST_PULSE_WIDTH: assert property (@(posedge refClk) disable iff (rst) // RL17
		sqPulseStart |-> (!syncWireOut && syncWireOe)[*8])
		else $error("wire pulse too short");

	// RL17 helper: length of the current drive-low stretch
	logic [CNT_W-1:0] lowRun_ff;
	always_ff @(posedge refClk) begin
		if (rst || !syncWireOe) begin
			lowRun_ff <= '0;
		end else begin
			lowRun_ff <= lowRun_ff + 1'b1;
		end
	end
	// RL17 pulse never overstays
	AST_PULSE_MAX: assert property (@(posedge refClk) disable iff (rst) // RL17
		lowRun_ff <= CNT_W'(PULSE_CYCLES))
		else $error("wire pulse too long");
	// RL17 pulse ends at full width
	AST_PULSE_FULL: assert property (@(posedge refClk) disable iff (rst) // RL17
		$fell(syncWireOe) |-> lowRun_ff == CNT_W'(PULSE_CYCLES))
		else $error("wire pulse width wrong");

	// RL2 no phase correction in disabled mode
	AST_OFF_SILENT: assert property (@(posedge refClk) disable iff (rst) // RL2
		(state_ff == SSC_ST_IDLE) |=> !phaseAdvance && !phaseRetard)
		else $error("correction while disabled");
	// RL4 leader never corrects phase
	AST_LEAD_NOFOLLOW: assert property (@(posedge refClk) disable iff (rst) // RL4
		(state_ff == SSC_ST_LEAD) |=> !phaseAdvance && !phaseRetard)
		else $error("leader followed a marker");
	// RL8 blocked while acquiring
	AST_BLOCK_ACQ: assert property (@(posedge refClk) disable iff (rst) // RL8
		(state_ff == SSC_ST_ACQUIRE && mode == SSC_MODE_FOLLOW && lockCnt_ff < CNT_W'(LOCK_CYCLES - 1)) |=> mediaBlocked)
		else $error("media not blocked");
	// RL6 leader-control refused
	AST_LEADCTL: assert property (@(posedge refClk) disable iff (rst) // RL6
		(mode == SSC_MODE_LEADCTL) |=> state_ff == SSC_ST_IDLE && modeRefused)
		else $error("leader-control accepted");
	// RL20 wire falling edge gives marker two cycles later
	AST_WIRE_EDGE: assert property (@(posedge refClk) disable iff (rst) // RL20
		$fell(syncWireIn) ##1 !syncWireIn |-> ##1 wireMarker)
		else $error("wire edge missed");
	// RL7 lock bound
	AST_LOCK_TIME: assert property (@(posedge refClk) disable iff (rst) // RL7
		lockCnt_ff <= CNT_W'(LOCK_CYCLES))
		else $error("lock took too long");

	// RL5 leader link marker two edges after the index
	sequence sqLeadLinkIdx;
		state_ff == SSC_ST_LEAD && !useWire && revIndex && !linkSyncInB;
	endsequence
	sequence sqPortAFree;
		!linkSyncInB && !portBusyA && !revIndex;
	endsequence
	AST_LEAD_LINK: assert property (@(posedge refClk) disable iff (rst) // RL5
		sqLeadLinkIdx ##1 sqPortAFree |=> linkSyncOutA)
		else $error("leader link marker missing");
	// RL4 leader wire pulse follows index
	AST_WIRE_LEAD: assert property (@(posedge refClk) disable iff (rst) // RL4
		(state_ff == SSC_ST_LEAD && useWire && revIndex) |=> syncWireOe && !syncWireOut)
		else $error("leader wire pulse missing");

	// RL2 wire released outside leader
	AST_OE_QUIET: assert property (@(posedge refClk) disable iff (rst) // RL2
		(state_ff != SSC_ST_LEAD && pulseCnt_ff <= CNT_W'(1)) |=> !syncWireOe)
		else $error("wire driven outside leader");
	// RL14 forwarded character is one cycle
	AST_LINK_ONE_B: assert property (@(posedge refClk) disable iff (rst) // RL14
		linkSyncOutB |=> !linkSyncOutB)
		else $error("port B character doubled");
	// RL14 forwarded character is one cycle
	AST_LINK_ONE_A: assert property (@(posedge refClk) disable iff (rst) // RL14
		linkSyncOutA |=> !linkSyncOutA)
		else $error("port A character doubled");
	// RL3 correction only on a marker
	AST_CORR_CAUSE: assert property (@(posedge refClk) disable iff (rst) // RL3
		(phaseAdvance || phaseRetard) |-> $past(rxMarker))
		else $error("correction without marker");
	// RL9 lock kept while following
	AST_LOCKED_HOLD: assert property (@(posedge refClk) disable iff (rst) // RL9
		(locked && mode == SSC_MODE_FOLLOW) |=> locked)
		else $error("lock dropped while following");
	// RL6 refusal clears with mode
	AST_REFUSE_CLR: assert property (@(posedge refClk) disable iff (rst) // RL6
		(mode != SSC_MODE_LEADCTL) |=> !modeRefused)
		else $error("refusal stuck");
endmodule

// ===== tb/ssc_far_drive.sv
// far-side drive acting as leader on the link or the wire
`timescale 1ns/10ps
module ssc_far_drive #(
	parameter int PERIOD = 1000,
	parameter int LOW_CYC = 60
) (
	input wire logic refClk,
	input wire logic rst,
	input wire logic enable,
	input wire logic viaWire,
	output logic linkSync,
	output logic wireOe
);
	int cnt;
	always_ff @(posedge refClk) begin
		if (rst || !enable) begin
			cnt <= 0;
			linkSync <= 1'b0;
			wireOe <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			linkSync <= !viaWire && cnt == PERIOD - 1;
			// low for more than one microsecond
			if (viaWire && cnt == PERIOD - 1)
				wireOe <= 1'b1;
			else if (cnt == LOW_CYC - 1)
				wireOe <= 1'b0;
		end
	end
endmodule

// ===== tb/testbench.sv
// self-checking bench for spindle sync control
`timescale 1ns/10ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errCount++; $display("BAD %0t mismatch", $time); end end
module testbench;
	import ssc_pkg::*;
	localparam int LOCK = 200;
	localparam int REV = 1000;
	logic refClk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [OFS_W-1:0] rotOffset = 8'h00;
	logic useWire = 1'b0;
	logic revIndex = 1'b0;
	logic inA = 1'b0, inB = 1'b0, busyA = 1'b0, busyB = 1'b0, farOn = 1'b0, spin = 1'b0, prevOe = 1'b0;
	logic wOut, wOe, outA, outB, adv, ret, locked, blocked, refused, farSync, farOe;
	wire logic wireLvl = !((wOe && !wOut) || farOe);
	int errCount, testsRun, nA, nB, nOe, nPh, nRev, spinCnt, k, preM, preR, preP;
	ssc_spindle_sync_control #(.LOCK_CYCLES(LOCK), .REV_CYCLES(REV), .TOL_CYCLES(10)) i_ssc_spindle_sync_control (
		.refClk(refClk), .rst(rst), .spindleLockModeField(mode), .rotOffset(rotOffset),
		.useWire(useWire), .revIndex(revIndex), .linkSyncInA(inA | farSync), .linkSyncInB(inB),
		.portBusyA(busyA), .portBusyB(busyB), .syncWireIn(wireLvl), .syncWireOut(wOut),
		.syncWireOe(wOe), .linkSyncOutA(outA), .linkSyncOutB(outB), .phaseAdvance(adv),
		.phaseRetard(ret), .locked(locked), .mediaBlocked(blocked), .modeRefused(refused));
	ssc_far_drive #(.PERIOD(REV)) i_ssc_far_drive (.refClk(refClk), .rst(rst), .enable(farOn),
		.viaWire(useWire), .linkSync(farSync), .wireOe(farOe));
	always #10 refClk = ~refClk;
	always @(posedge refClk) begin
		nA += outA;
		nB += outB;
		nPh += adv + ret;
		nRev += revIndex;
		nOe += wOe && !prevOe;
		prevOe = wOe;
		if (spin) begin
			spinCnt = (spinCnt + 1) % REV;
			revIndex <= (spinCnt == 0);
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge refClk);
	endtask
	task automatic fwd(input bit toB, input bit busy);
		@(posedge refClk);
		{inA, inB, busyA, busyB} <= {toB, !toB, busy && !toB, busy && toB};
		@(posedge refClk);
		{inA, inB} <= 2'h0;
		#1;
		k = 0;
		while (k < 40 && (toB ? outB : outA) !== 1'b1) begin
			@(posedge refClk);
			if (k == FWD_DELAY_CYC)
				{busyA, busyB} <= 2'h0;
			#1;
			k++;
		end
		`CHK(k * CLK_NS inside {[FWD_DELAY_NS - 50 : FWD_DELAY_NS + 50 + 100 * busy]}, 1'b1)
	endtask
	initial begin
		void'($urandom(32'h2C9B6E8F));
		tick(12);
		rst <= 1'b0;
		#1;
		`CHK({wOut, wOe, outA, outB, adv, ret, locked, blocked, refused}, 9'h100)
		for (int i = 0; i < 8; i++) begin
			fwd(1'(i % 2), i < 2 ? 1'b0 : 1'($urandom_range(1)));
			tick(4);
		end
		$display("forwarding done");
		for (int j = 0; j < 2; j++) begin
			@(posedge refClk);
			{mode, useWire, farOn, spin} <= {j ? 2'h3 : 2'h0, 1'($urandom_range(1)), 2'h3};
			rotOffset <= 8'($urandom_range(255));
			tick(3);
			preM = nPh + nOe + nA;
			tick(2500);
			`CHK(nPh + nOe + nA - preM, 0)
			`CHK({refused, blocked, locked}, {1'(j), 2'h0})
		end
		$display("idle modes done");
		for (int w = 0; w < 2; w++) begin
			@(posedge refClk);
			{mode, useWire, farOn, spin} <= {2'h2, 1'(w), 1'b0, 1'b1};
			tick(3);
			#1;
			{preM, preR, preP} = {w ? nOe : nA, nRev, nPh};
			tick(2500);
			spin <= 1'b0;
			tick(120);
			`CHK((w ? nOe : nA) - preM, nRev - preR)
			`CHK(nPh - preP, 0)
			revIndex <= 1'b1;
			@(posedge refClk);
			revIndex <= 1'b0;
			tick(1);
			#1;
			`CHK(w ? wOe && !wOut && !wireLvl : outA, 1'b1)
			tick(w ? 98 : 1);
			#1;
			`CHK(w ? wOe : outA, 1'(w))
			tick(1);
			#1;
			`CHK(w ? wOe : outA, 1'b0)
		end
		$display("leader done");
		@(posedge refClk);
		{mode, useWire, farOn, spin} <= {2'h1, 1'($urandom_range(1)), 2'h3};
		rotOffset <= 8'($urandom_range(1, 40));
		spinCnt = 300;
		tick(2);
		#1;
		`CHK({blocked, locked}, 2'h2)
		tick(LOCK + 2);
		#1;
		`CHK({blocked, locked}, 2'h1)
		preP = nPh;
		tick(3 * REV);
		`CHK(nPh > preP, 1'b1)
		$display("follower done");
		test_done();
	end
	initial begin
		tick(40000);
		errCount++;
		test_done();
	end
endmodule
